// ==== agu_address_arithmetic.sv ====
`timescale 1ns/1ps
module agu_address_arithmetic #(
  parameter int W = 16
) (
  input  wire logic                    clock,         // core clock
  input  wire logic                    resetn,        // async reset, active low
  input  wire logic                    issue,         // address calculation request
  input  wire agu_pkg::agu_mode_e      mode,          // addressing mode
  input  wire logic [2:0]              ptr_sel,       // selected pointer
  input  wire logic [W-1:0]            disp,          // long displacement or absolute word
  input  wire logic [5:0]              short_field,   // 6-bit instruction field
  input  wire logic                    dual_read,     // request dual data read
  input  wire agu_pkg::agu_implicit_e  implicit_sel,  // implied register
  input  wire logic                    mod_we,        // write modifier register
  input  wire logic                    ptr_we,        // write a pointer directly
  input  wire logic                    index_we,      // write index offset register
  input  wire logic [W-1:0]            wdata,         // register write data
  output logic      [W-1:0]            address,       // effective address
  output logic                         address_valid, // address strobe
  output logic                         uses_modifier, // mode consulted modifier
  output logic                         prog_ref,      // program memory reference
  output logic                         xmem_ref,      // data memory reference
  output logic                         dual_ok,       // dual read legal
  output logic                         implicit_ref,  // implicit register access
  output logic      [2:0]              implicit_reg,  // which implicit register
  output logic      [W-1:0]            address_modifier_reg, // modifier value
  output logic      [W-1:0]            pointer_reg_zero,
  output logic      [W-1:0]            pointer_reg_one,
  output logic      [W-1:0]            pointer_reg_two,
  output logic      [W-1:0]            pointer_reg_three,
  output logic      [W-1:0]            stack_ptr,
  output logic      [W-1:0]            index_offset
);
  // decode modifier fields
  wire logic [1:0]  mod_mode = address_modifier_reg[15:agu_pkg::MODE_LSB];
  wire logic [13:0] mod_size = address_modifier_reg[agu_pkg::SIZE_W-1:0];
  // all ones is the reset value and always means plain linear arithmetic
  wire logic        mod_lin  = (address_modifier_reg == agu_pkg::MOD_RESET) ||
                               (mod_mode == agu_pkg::MODE_LINEAR);

  // modes that consult the modifier
  wire logic mode_mod = (mode == agu_pkg::AGU_M_POST_INC) || (mode == agu_pkg::AGU_M_POST_DEC) ||
                        (mode == agu_pkg::AGU_M_POST_OFFSET) || (mode == agu_pkg::AGU_M_INDEX_OFFSET) ||
                        (mode == agu_pkg::AGU_M_LONG_DISP);

  // modulo only on pointer zero, or one when mode allows
  wire logic ptr_mod = (ptr_sel == agu_pkg::PTR_ZERO) ||
                       (ptr_sel == agu_pkg::PTR_ONE && mod_mode == agu_pkg::MODE_PTR0_ONE);
  // reserved modifier codes are not trapped: the decode above still picks a
  // deterministic arithmetic for them, so software must avoid those values
  wire logic use_mod = mode_mod && ptr_mod && !mod_lin;

  // these modes consult the modifier on pointers zero and one, even when it
  // then selects linear arithmetic; other pointers never look at it
  wire logic ptr_low  = (ptr_sel == agu_pkg::PTR_ZERO) || (ptr_sel == agu_pkg::PTR_ONE);
  wire logic consults = mode_mod && ptr_low;

  // selected pointer value
  // select codes above the stack pointer also fall to the stack pointer
  logic [W-1:0] base;
  always_comb begin
    case (ptr_sel)
      agu_pkg::PTR_ZERO:  base = pointer_reg_zero;
      agu_pkg::PTR_ONE:   base = pointer_reg_one;
      agu_pkg::PTR_TWO:   base = pointer_reg_two;
      agu_pkg::PTR_THREE: base = pointer_reg_three;
      default:            base = stack_ptr;
    endcase
  end

  // offset choice per mode
  // post-decrement adds all ones, which is minus one in two's complement
  // short displacement: one-extended (negative) on the stack, else zero-extended
  logic [W-1:0] offset;
  always_comb begin
    case (mode)
      agu_pkg::AGU_M_POST_INC:     offset = W'(1);
      agu_pkg::AGU_M_POST_DEC:     offset = {W{1'b1}};
      agu_pkg::AGU_M_POST_OFFSET,
      agu_pkg::AGU_M_INDEX_OFFSET: offset = index_offset;
      agu_pkg::AGU_M_LONG_DISP:    offset = disp;
      agu_pkg::AGU_M_SHORT_DISP:   offset = (ptr_sel == agu_pkg::PTR_STACK) ?
                                            {{(W-6){1'b1}}, short_field} :
                                            {{(W-6){1'b0}}, short_field};
      default:                     offset = '0;
    endcase
  end

  // modulo/linear result
  logic [W-1:0] updated;
  agu_modulo_update #(.W(W)) u_upd (
    .base       (base),
    .offset     (offset),
    .size_m1    (mod_size),
    .use_modulo (use_mod),
    .result     (updated)
  );

  // which modes write the pointer back
  // indexed modes only form an address and leave the pointer untouched
  wire logic writes_ptr = (mode == agu_pkg::AGU_M_POST_INC) || (mode == agu_pkg::AGU_M_POST_DEC) ||
                          (mode == agu_pkg::AGU_M_POST_OFFSET);
  // indexed modes use the computed sum as address
  wire logic indexed = (mode == agu_pkg::AGU_M_INDEX_OFFSET) || (mode == agu_pkg::AGU_M_LONG_DISP) ||
                       (mode == agu_pkg::AGU_M_SHORT_DISP);

  // effective address per mode
  // absolute short reaches the low 64 words, I/O short the top 64 words
  logic [W-1:0] next_address;
  always_comb begin
    case (mode)
      agu_pkg::AGU_M_ABSOLUTE: next_address = disp;
      agu_pkg::AGU_M_ABS_SHORT: next_address = {{(W-6){1'b0}}, short_field};
      agu_pkg::AGU_M_IO_SHORT:  next_address = {{(W-6){1'b1}}, short_field};
      default:                  next_address = indexed ? updated : base;
    endcase
  end

  // modes fit for a dual data read; they also serve program memory
  function automatic logic agu_dual_mode(input agu_pkg::agu_mode_e m);
    return (m == agu_pkg::AGU_M_POST_INC) || (m == agu_pkg::AGU_M_POST_OFFSET);
  endfunction : agu_dual_mode

  // reference classes
  // data memory: every mode but register direct and the two immediates
  wire logic is_xmem = (mode != agu_pkg::AGU_M_REG_DIRECT) && (mode != agu_pkg::AGU_M_IMMEDIATE) &&
                       (mode != agu_pkg::AGU_M_IMM_SHORT);
  // program memory: dual-capable modes, immediates, absolute and implicit
  wire logic is_prog = agu_dual_mode(mode) ||
                       (mode == agu_pkg::AGU_M_IMMEDIATE) || (mode == agu_pkg::AGU_M_IMM_SHORT) ||
                       (mode == agu_pkg::AGU_M_ABSOLUTE) || (mode == agu_pkg::AGU_M_IMPLICIT);
  // dual read: post-increment by one and post-update by index only
  wire logic is_dual = agu_dual_mode(mode);
  // implicit: control registers reached with no operand field
  wire logic is_impl = (mode == agu_pkg::AGU_M_IMPLICIT);

  // modifier register, takes effect on the next calculation
  // a write at one edge governs every request taken from the next edge on
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      address_modifier_reg <= agu_pkg::MOD_RESET;
    end else if (mod_we) begin
      address_modifier_reg <= wdata;
    end
  end

  // index offset register
  // held as a plain word; the adder treats it as a signed offset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      index_offset <= '0;
    end else if (index_we) begin
      index_offset <= wdata;
    end
  end

  // pointer registers: direct write or post-update
  // a direct write and a post-update in one cycle: the direct write wins
  wire logic upd = issue && writes_ptr;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pointer_reg_zero  <= '0;
      pointer_reg_one   <= '0;
      pointer_reg_two   <= '0;
      pointer_reg_three <= '0;
      stack_ptr         <= '0;
    end else if (ptr_we || upd) begin
      case (ptr_sel)
        agu_pkg::PTR_ZERO:  pointer_reg_zero  <= ptr_we ? wdata : updated;
        agu_pkg::PTR_ONE:   pointer_reg_one   <= ptr_we ? wdata : updated;
        agu_pkg::PTR_TWO:   pointer_reg_two   <= ptr_we ? wdata : updated;
        agu_pkg::PTR_THREE: pointer_reg_three <= ptr_we ? wdata : updated;
        default:            stack_ptr         <= ptr_we ? wdata : updated;
      endcase
    end
  end

  // registered address, strobe and implied register select
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      address       <= '0;
      address_valid <= 1'b0;
      implicit_reg  <= 3'h0;
    end else begin
      address       <= next_address;  // pre-update value for post modes
      address_valid <= issue;         // strobe one cycle after the request
      implicit_reg  <= implicit_sel;
    end
  end

  // registered classification flags, one-cycle pulses beside the strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      uses_modifier <= 1'b0;
      prog_ref      <= 1'b0;
      xmem_ref      <= 1'b0;
      dual_ok       <= 1'b0;
      implicit_ref  <= 1'b0;
    end else begin
      uses_modifier <= issue && consults;
      prog_ref      <= issue && is_prog;
      xmem_ref      <= issue && is_xmem;
      dual_ok       <= issue && dual_read && is_dual;
      implicit_ref  <= issue && is_impl;
    end
  end
endmodule : agu_address_arithmetic

// ==== agu_address_arithmetic_monitor.sv ====
`timescale 1ns/1ps
// port-level checks of the address arithmetic block
module agu_address_arithmetic_monitor (
  input wire logic                   clock,
  input wire logic                   resetn,
  input wire logic                   issue,
  input wire agu_pkg::agu_mode_e     mode,
  input wire logic [2:0]             ptr_sel,
  input wire agu_pkg::agu_implicit_e implicit_sel,
  input wire logic                   ptr_we,
  input wire logic [15:0]            address,
  input wire logic                   uses_modifier,
  input wire logic                   dual_ok,
  input wire logic                   implicit_ref,
  input wire logic [2:0]             implicit_reg,
  input wire logic [15:0]            address_modifier_reg,
  input wire logic [15:0]            pointer_reg_zero,
  input wire logic [15:0]            pointer_reg_one,
  input wire logic [15:0]            pointer_reg_two,
  input wire logic [15:0]            stack_ptr,
  input wire logic [15:0]            index_offset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // modes that consult the modifier
  wire logic mod_mode = mode inside {agu_pkg::AGU_M_POST_INC, agu_pkg::AGU_M_POST_DEC,
    agu_pkg::AGU_M_POST_OFFSET, agu_pkg::AGU_M_INDEX_OFFSET, agu_pkg::AGU_M_LONG_DISP};
  // plain issue with no competing pointer write
  wire logic go = issue && !ptr_we;
  // bits a modulo update must leave alone: all above the power-of-two span
  logic [15:0] keep;
  always_comb begin
    keep = 16'hFFFF;
    for (int i = 0; i < 14; i++) begin
      if (address_modifier_reg[i]) begin
        keep = 16'hFFFF << (i + 1);
      end
    end
  end
  property p_reset_mod; $rose(resetn) |-> address_modifier_reg == 16'hFFFF; endproperty
  a_reset_mod: assert property (p_reset_mod) else $error("modifier not all ones after reset");
  property p_lin_inc; go && mode == agu_pkg::AGU_M_POST_INC && ptr_sel == agu_pkg::PTR_TWO
    |=> address == $past(pointer_reg_two) && pointer_reg_two == $past(pointer_reg_two) + 16'h0001; endproperty
  a_lin_inc: assert property (p_lin_inc) else $error("linear increment wrong");
  property p_stack_off; go && mode == agu_pkg::AGU_M_POST_OFFSET && ptr_sel == agu_pkg::PTR_STACK
    |=> stack_ptr == $past(stack_ptr) + $past(index_offset); endproperty
  a_stack_off: assert property (p_stack_off) else $error("stack offset update wrong");
  property p_ffff; go && mode == agu_pkg::AGU_M_POST_DEC && ptr_sel == agu_pkg::PTR_ZERO
    && address_modifier_reg == 16'hFFFF |=> pointer_reg_zero == $past(pointer_reg_zero) - 16'h0001; endproperty
  a_ffff: assert property (p_ffff) else $error("linear decrement wrong");
  // consulted by the listed modes on pointers zero and one only
  property p_uses; issue |=> uses_modifier == $past(mod_mode && ptr_sel <= agu_pkg::PTR_ONE); endproperty
  a_uses: assert property (p_uses) else $error("modifier use flag wrong");
  property p_one_lin; go && mode == agu_pkg::AGU_M_POST_INC && ptr_sel == agu_pkg::PTR_ONE
    && address_modifier_reg[15:14] == 2'h0 |=> pointer_reg_one == $past(pointer_reg_one) + 16'h0001; endproperty
  a_one_lin: assert property (p_one_lin) else $error("pointer one not linear");
  property p_mod_up; go && mod_mode && ptr_sel == agu_pkg::PTR_ZERO && !address_modifier_reg[14]
    && address_modifier_reg[13:0] != 14'h0000
    |=> (pointer_reg_zero & $past(keep)) == ($past(pointer_reg_zero) & $past(keep)); endproperty
  a_mod_up: assert property (p_mod_up) else $error("modulo changed upper bits");
  property p_dual; issue && !(mode inside {agu_pkg::AGU_M_POST_INC, agu_pkg::AGU_M_POST_OFFSET}) |=> !dual_ok; endproperty
  a_dual: assert property (p_dual) else $error("dual read allowed wrongly");
  property p_impl; issue && mode == agu_pkg::AGU_M_IMPLICIT |=> implicit_ref && implicit_reg == $past(implicit_sel); endproperty
  a_impl: assert property (p_impl) else $error("implicit access not flagged");
endmodule : agu_address_arithmetic_monitor

// ==== agu_address_arithmetic_tb.sv ====
`timescale 1ns/1ps
// self-checking bench; inputs change on the falling edge
module agu_address_arithmetic_tb;
  logic                  clock = 1'b0, resetn = 1'b0, issue = 1'b0, dual_read = 1'b1;
  logic                  mod_we = 1'b0, ptr_we = 1'b0, index_we = 1'b0;
  logic [2:0]            ptr_sel = 3'h0;
  logic [15:0]           disp = 16'h0000, wdata = 16'h0000;
  logic [5:0]            short_field = 6'h00;
  agu_pkg::agu_mode_e    mode = agu_pkg::AGU_M_REG_DIRECT;
  agu_pkg::agu_implicit_e implicit_sel = agu_pkg::AGU_I_PC;
  logic [15:0]           address, address_modifier_reg, pointer_reg_zero, pointer_reg_one, last_xaddr;
  logic [15:0]           pointer_reg_two, pointer_reg_three, stack_ptr, index_offset;
  logic                  address_valid, uses_modifier, prog_ref, xmem_ref, dual_ok, implicit_ref;
  logic [2:0]            implicit_reg;
  int                    err_count = 0, check_count = 0;
  agu_address_arithmetic i_dut (
    .clock                (clock),
    .resetn               (resetn),
    .issue                (issue),
    .mode                 (mode),
    .ptr_sel              (ptr_sel),
    .disp                 (disp),
    .short_field          (short_field),
    .dual_read            (dual_read),
    .implicit_sel         (implicit_sel),
    .mod_we               (mod_we),
    .ptr_we               (ptr_we),
    .index_we             (index_we),
    .wdata                (wdata),
    .address              (address),
    .address_valid        (address_valid),
    .uses_modifier        (uses_modifier),
    .prog_ref             (prog_ref),
    .xmem_ref             (xmem_ref),
    .dual_ok              (dual_ok),
    .implicit_ref         (implicit_ref),
    .implicit_reg         (implicit_reg),
    .address_modifier_reg (address_modifier_reg),
    .pointer_reg_zero     (pointer_reg_zero),
    .pointer_reg_one      (pointer_reg_one),
    .pointer_reg_two      (pointer_reg_two),
    .pointer_reg_three    (pointer_reg_three),
    .stack_ptr            (stack_ptr),
    .index_offset         (index_offset)
  );
  agu_xmem_model         i_mem (
    .clock         (clock),
    .resetn        (resetn),
    .address       (address),
    .address_valid (address_valid),
    .xmem_ref      (xmem_ref),
    .last_xaddr    (last_xaddr)
  );
  // core clock, 25 ns period
  initial forever #12.5 clock = ~clock;
  // compare one value and report a mismatch
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // register write: 0 modifier, 1 pointer, 2 index
  task automatic wr(input int kind, input logic [2:0] p, input logic [15:0] d);
    @(negedge clock);
    ptr_sel = p;
    wdata = d;
    {mod_we, ptr_we, index_we} = {kind == 0, kind == 1, kind == 2};
    @(negedge clock);
    {mod_we, ptr_we, index_we} = 3'h0;
  endtask : wr
  // one address calculation; outputs are settled on return
  task automatic op(input agu_pkg::agu_mode_e m, input logic [2:0] p, input logic [5:0] f);
    @(negedge clock);
    issue = 1'b1;
    mode = m;
    ptr_sel = p;
    short_field = f;
    @(negedge clock);
    issue = 1'b0;
  endtask : op
  // linear wrap at both ends and a negative offset
  task automatic t_linear;
    wr(1, agu_pkg::PTR_TWO, 16'hFFFF);
    op(agu_pkg::AGU_M_POST_INC, agu_pkg::PTR_TWO, 6'h00);
    chk("addr", address, 16'hFFFF);
    chk("ptr2", pointer_reg_two, 16'h0000);
    wr(1, agu_pkg::PTR_THREE, 16'h0000);
    op(agu_pkg::AGU_M_POST_DEC, agu_pkg::PTR_THREE, 6'h00);
    chk("ptr3", pointer_reg_three, 16'hFFFF);
    wr(2, 3'h0, 16'hFFFE);
    chk("index", index_offset, 16'hFFFE);
    wr(1, agu_pkg::PTR_STACK, 16'h0005);
    op(agu_pkg::AGU_M_POST_OFFSET, agu_pkg::PTR_STACK, 6'h00);
    chk("sp", stack_ptr, 16'h0003);
  endtask : t_linear
  // every mode on pointer zero: modifier use and dual read flags
  task automatic t_modes;
    agu_pkg::agu_mode_e m;
    for (int i = 0; i < 14; i++) begin
      m = agu_pkg::agu_mode_e'(i);
      implicit_sel = agu_pkg::agu_implicit_e'(i % 6);
      op(m, agu_pkg::PTR_ZERO, 6'h00);
      chk("uses", {15'h0000, uses_modifier}, {15'h0000, i inside {2, 3, 4, 5, 7}});
      chk("dual", {15'h0000, dual_ok}, {15'h0000, i inside {2, 4}});
      chk("valid", {15'h0000, address_valid}, 16'h0001);
      chk("prog", {15'h0000, prog_ref}, {15'h0000, i inside {2, 4, 8, 9, 10, 13}});
      chk("xmem", {15'h0000, xmem_ref}, {15'h0000, !(i inside {0, 8, 9})});
      chk("impl", {15'h0000, implicit_ref}, {15'h0000, i == 13});
      chk("impl reg", {13'h0000, implicit_reg}, 16'(i % 6));
    end
    // no dual read unless the decoder asks for one
    dual_read = 1'b0;
    op(agu_pkg::AGU_M_POST_INC, agu_pkg::PTR_ZERO, 6'h00);
    chk("dual off", {15'h0000, dual_ok}, 16'h0000);
    dual_read = 1'b1;
    @(negedge clock);
    chk("prog idle", {15'h0000, prog_ref}, 16'h0000);
  endtask : t_modes
  // modulo five on both pointers, then pointer zero only
  task automatic t_modulo;
    wr(1, agu_pkg::PTR_ONE, 16'h0104);
    wr(0, 3'h0, 16'h8004);
    op(agu_pkg::AGU_M_POST_INC, agu_pkg::PTR_ONE, 6'h00);
    chk("ptr1 wrap", pointer_reg_one, 16'h0100);
    wr(1, agu_pkg::PTR_ZERO, 16'h0100);
    op(agu_pkg::AGU_M_POST_DEC, agu_pkg::PTR_ZERO, 6'h00);
    chk("ptr0 wrap", pointer_reg_zero, 16'h0104);
    wr(1, agu_pkg::PTR_ONE, 16'h0104);
    wr(0, 3'h0, 16'h0004);
    op(agu_pkg::AGU_M_POST_INC, agu_pkg::PTR_ONE, 6'h00);
    chk("ptr1 lin", pointer_reg_one, 16'h0105);
  endtask : t_modulo
  // short displacement extension on pointer two and stack
  task automatic t_short;
    wr(1, agu_pkg::PTR_TWO, 16'h0010);
    op(agu_pkg::AGU_M_SHORT_DISP, agu_pkg::PTR_TWO, 6'h03);
    chk("disp r2", address, 16'h0013);
    @(negedge clock);
    chk("xmem", last_xaddr, 16'h0013);
    wr(1, agu_pkg::PTR_STACK, 16'h0010);
    op(agu_pkg::AGU_M_SHORT_DISP, agu_pkg::PTR_STACK, 6'h3D);
    chk("disp sp", address, 16'h000D);
  endtask : t_short
  // verdict and end of run
  task automatic end_sim;
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // reset, then scenarios in turn
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    chk("mod", address_modifier_reg, 16'hFFFF);
    t_linear();
    t_modes();
    t_modulo();
    t_short();
    end_sim();
  end
endmodule : agu_address_arithmetic_tb
bind agu_address_arithmetic agu_address_arithmetic_monitor i_mon (
  .clock                (clock),
  .resetn               (resetn),
  .issue                (issue),
  .mode                 (mode),
  .ptr_sel              (ptr_sel),
  .implicit_sel         (implicit_sel),
  .ptr_we               (ptr_we),
  .address              (address),
  .uses_modifier        (uses_modifier),
  .dual_ok              (dual_ok),
  .implicit_ref         (implicit_ref),
  .implicit_reg         (implicit_reg),
  .address_modifier_reg (address_modifier_reg),
  .pointer_reg_zero     (pointer_reg_zero),
  .pointer_reg_one      (pointer_reg_one),
  .pointer_reg_two      (pointer_reg_two),
  .stack_ptr            (stack_ptr),
  .index_offset         (index_offset)
);

// ==== agu_modulo_update.sv ====
`timescale 1ns/1ps
// modulo or linear update of one pointer value
module agu_modulo_update #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] base,       // current pointer value
  input  wire logic [W-1:0] offset,     // signed offset
  input  wire logic [13:0]  size_m1,    // buffer size minus one
  input  wire logic         use_modulo, // wrap inside buffer
  output logic      [W-1:0] result      // updated pointer
);
  // mask of low k bits covering size rounded to power of two
  function automatic logic [W-1:0] agu_mask(input logic [13:0] s);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < 14; i++) begin
      if (s[i]) begin
        m = (W'(1) << (i + 1)) - W'(1);
      end
    end
    return m;
  endfunction : agu_mask

  wire logic [W-1:0] mask    = agu_mask(size_m1);
  wire logic [W-1:0] modlen  = W'(size_m1) + W'(1);            // buffer length
  wire logic [W-1:0] lin_sum = base + offset;                  // wraps modulo 64K
  wire logic [W-1:0] low     = base & mask;
  wire logic         neg     = offset[W-1];                    // signed offset
  // low bits plus offset, folded into 0..size-1
  wire logic [W-1:0] low_dn  = low + offset;
  wire logic [W-1:0] fold_up = (low + offset >= modlen) ? (low + offset - modlen) : (low + offset);
  wire logic [W-1:0] fold_dn = (low < (W'(0) - offset)) ? (low + offset + modlen) : low_dn;
  wire logic [W-1:0] folded  = neg ? fold_dn : fold_up;

  // keep upper bits, replace low k bits
  assign result = use_modulo ? ((base & ~mask) | (folded & mask)) : lin_sum;
endmodule : agu_modulo_update

// ==== agu_pkg.sv ====
package agu_pkg;
  // data path width of every address quantity
  localparam int ADDR_W = 16;
  // address modifier register after reset: linear on both pointers
  localparam logic [15:0] MOD_RESET = 16'hFFFF;
  // mode field values held in the top two modifier bits
  localparam logic [1:0] MODE_PTR0_ONLY = 2'h0;
  localparam logic [1:0] MODE_PTR0_ONE  = 2'h2;
  localparam logic [1:0] MODE_LINEAR    = 2'h3;
  // position of the mode field and width of the size field
  localparam int MODE_LSB = 14;
  localparam int SIZE_W   = 14;
  // pointer selects
  localparam logic [2:0] PTR_ZERO  = 3'h0;
  localparam logic [2:0] PTR_ONE   = 3'h1;
  localparam logic [2:0] PTR_TWO   = 3'h2;
  localparam logic [2:0] PTR_THREE = 3'h3;
  localparam logic [2:0] PTR_STACK = 3'h4;
  // addressing modes issued by the decoder
  typedef enum logic [4:0] {
    AGU_M_REG_DIRECT, AGU_M_NO_UPDATE, AGU_M_POST_INC, AGU_M_POST_DEC,
    AGU_M_POST_OFFSET, AGU_M_INDEX_OFFSET, AGU_M_SHORT_DISP, AGU_M_LONG_DISP,
    AGU_M_IMMEDIATE, AGU_M_IMM_SHORT, AGU_M_ABSOLUTE, AGU_M_ABS_SHORT,
    AGU_M_IO_SHORT, AGU_M_IMPLICIT
  } agu_mode_e;
  // implicit register selects
  typedef enum logic [2:0] {
    AGU_I_PC, AGU_I_SW_STACK, AGU_I_HW_STACK, AGU_I_LOOP_ADDR, AGU_I_LOOP_COUNT, AGU_I_STATUS
  } agu_implicit_e;
endpackage : agu_pkg

// ==== agu_xmem_model.sv ====
`timescale 1ns/1ps
// data memory side: latches each data memory address the block strobes out
module agu_xmem_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [15:0] address,
  input  wire logic        address_valid,
  input  wire logic        xmem_ref,
  output logic      [15:0] last_xaddr
);
  // capture only strobed data memory references
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      last_xaddr <= 16'h0000;
    end else if (address_valid && xmem_ref) begin
      last_xaddr <= address;
    end
  end
endmodule : agu_xmem_model
